// *** design/pcf_pkg.sv ***
package pcf_pkg;

  // Reset vector location, high byte first
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [15:0] PTR_STEP    = 16'h0001;

  // Condition flag bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_I = 3;
  localparam int unsigned FLG_H = 4;
  localparam int unsigned FLG_V = 7;
  localparam int unsigned BYTE_MSB = 7;
  localparam int unsigned NIB_CARRY = 4;

  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [7:0] BYTE_ONES   = 8'hFF;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  // Decimal adjust constants
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
  localparam logic [7:0] BCD_LO_FIX    = 8'h06;
  localparam logic [7:0] BCD_HI_FIX    = 8'h60;

  // Register port map
  localparam logic [3:0] REG_FLAGS  = 4'h0;
  localparam logic [3:0] REG_PTR_LO = 4'h1;
  localparam logic [3:0] REG_PTR_HI = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_INHIBIT = 1;

  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_FETCH    = 4'h1,
    OP_REGONLY  = 4'h2,
    OP_IMM8     = 4'h3,
    OP_IMM16    = 4'h4,
    OP_OFFSET   = 4'h5,
    OP_JUMP     = 4'h6,
    OP_FLAGS    = 4'h7,
    OP_MASK_SET = 4'h8,
    OP_MASK_CLR = 4'h9,
    OP_DECADJ   = 4'hA,
    OP_BOUNDARY = 4'hB
  } pcf_op_t;

  typedef enum logic [2:0] {
    K_ADD    = 3'h0,
    K_ADC    = 3'h1,
    K_SUB    = 3'h2,
    K_SBC    = 3'h3,
    K_LOGIC  = 3'h4,
    K_LOAD16 = 3'h5,
    K_SHIFT  = 3'h6
  } pcf_kind_t;

  typedef enum logic [7:0] {
    ST_RV0  = 8'h01,
    ST_RV1  = 8'h02,
    ST_RV2  = 8'h04,
    ST_RV3  = 8'h08,
    ST_IDLE = 8'h10,
    ST_W1   = 8'h20,
    ST_D1   = 8'h40,
    ST_D2   = 8'h80
  } pcf_state_t;

endpackage : pcf_pkg

// *** design/pcf_core.sv ***
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module pcf_core
  import pcf_pkg::*;
(
  input  wire logic        REF_CLK,     // 200 MHz core clock
  input  wire logic        RST_B,       // Synchronous reset, active low
  input  wire logic        CLK_EN,      // Freezes all state when low
  input  wire logic        CMD_VALID,   // Command strobe from sequencer
  input  wire pcf_op_t     CMD_OP,      // Command code
  input  wire logic        CMD_COND,    // Branch condition true
  input  wire logic        CMD_CBIT,    // Carry from shift or bit test
  input  wire logic [15:0] CMD_TARGET,  // Change-of-flow target
  input  wire pcf_kind_t   ALU_KIND,    // Flag update kind
  input  wire logic [7:0]  ALU_A,       // Accumulator side operand
  input  wire logic [7:0]  ALU_B,       // Second operand
  input  wire logic [15:0] ALU_W,       // Sixteen-bit loaded value
  input  wire logic        IRQ_REQ,     // Maskable interrupt pending
  input  wire logic [7:0]  MEM_RDATA,   // Memory data, cycle after read
  input  wire logic [3:0]  REG_ADDR,    // Register port address
  input  wire logic [7:0]  REG_WDATA,   // Register port write data
  input  wire logic        REG_WR,      // Register write strobe
  input  wire logic        REG_RD,      // Register read strobe
  output logic [7:0]       REG_RDATA,   // Register read data
  output logic [15:0]      MEM_ADDR,    // Unified bus address
  output logic             MEM_RD,      // Unified bus read strobe
  output logic [15:0]      FETCH_PTR,   // Next fetch pointer
  output logic [7:0]       FLAGS,       // Condition flags
  output logic [15:0]      OPERAND,     // Fetched operand or result
  output logic             DONE,        // Command finished pulse
  output logic             BUSY,        // Fetch sequence running
  output logic             IRQ_GRANT    // Interrupt recognised pulse
);

  pcf_state_t  state;
  pcf_state_t  next_state;
  pcf_op_t     op_q;
  pcf_op_t     next_op;
  logic [15:0] next_fetch_pointer;
  logic [15:0] fetch_pointer;
  logic [7:0]  condition_flags;
  logic [7:0]  next_flags;
  logic [15:0] mem_addr;
  logic [15:0] next_mem_addr;
  logic        mem_rd;
  logic        next_mem_rd;
  logic [15:0] operand;
  logic [15:0] next_operand;
  logic        done;
  logic        next_done;
  logic        busy;
  logic        next_busy;
  logic        grant;
  logic        next_grant;
  logic        inhibit;
  logic        next_inhibit;
  logic        cond_q;
  logic        next_cond;
  logic [7:0]  hi_byte;
  logic [7:0]  next_hi;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;

  logic [8:0]  add9;
  logic [8:0]  sub9;
  logic        cin;
  logic [7:0]  alu_flags;
  logic [7:0]  alu_res;
  logic [7:0]  daa_fix;
  logic [7:0]  daa_res;
  logic [7:0]  daa_flags;
  logic        take;

  assign take = CMD_VALID && (state == ST_IDLE);

  // Flag arithmetic for the command now offered
  always_comb begin
    cin = ((ALU_KIND == K_ADC) || (ALU_KIND == K_SBC)) ?
          condition_flags[FLG_C] : 1'b0;
    add9 = {1'b0, ALU_A} + {1'b0, ALU_B} + {8'h00, cin};
    sub9 = {1'b0, ALU_A} - {1'b0, ALU_B} - {8'h00, cin};
    alu_flags = condition_flags;
    alu_res = ALU_A;
    unique case (ALU_KIND)
      K_ADD, K_ADC: begin
        alu_res = add9[7:0];
        alu_flags[FLG_C] = add9[8];
        alu_flags[FLG_V] = (ALU_A[BYTE_MSB] == ALU_B[BYTE_MSB]) &&
                           (alu_res[BYTE_MSB] != ALU_A[BYTE_MSB]);
        alu_flags[FLG_H] = ALU_A[NIB_CARRY] ^ ALU_B[NIB_CARRY] ^
                           alu_res[NIB_CARRY];
      end
      K_SUB, K_SBC: begin
        alu_res = sub9[7:0];
        alu_flags[FLG_C] = sub9[8];
        alu_flags[FLG_V] = (ALU_A[BYTE_MSB] != ALU_B[BYTE_MSB]) &&
                           (alu_res[BYTE_MSB] != ALU_A[BYTE_MSB]);
      end
      K_LOGIC: begin
        alu_flags[FLG_V] = 1'b0;
      end
      K_LOAD16: begin
        alu_flags[FLG_V] = 1'b0;
      end
      K_SHIFT: begin
        alu_flags[FLG_C] = CMD_CBIT;
      end
      default: begin
        alu_res = ALU_A;
      end
    endcase
    if (ALU_KIND == K_LOAD16) begin
      alu_flags[FLG_N] = ALU_W[15];
      alu_flags[FLG_Z] = (ALU_W == WORD_ZERO);
    end else begin
      alu_flags[FLG_N] = alu_res[BYTE_MSB];
      alu_flags[FLG_Z] = (alu_res == BYTE_ZERO);
    end
    // Decimal correction of a prior binary add
    daa_fix = BYTE_ZERO;
    daa_flags = condition_flags;
    if (condition_flags[FLG_H] || (ALU_A[3:0] > BCD_DIGIT_MAX)) begin
      daa_fix = daa_fix | BCD_LO_FIX;
    end
    if (condition_flags[FLG_C] || (ALU_A > BCD_BYTE_MAX)) begin
      daa_fix = daa_fix | BCD_HI_FIX;
      daa_flags[FLG_C] = 1'b1;
    end
    daa_res = ALU_A + daa_fix;
    daa_flags[FLG_N] = daa_res[BYTE_MSB];
    daa_flags[FLG_Z] = (daa_res == BYTE_ZERO);
  end

  always_comb begin
    next_state = state;
    next_op = op_q;
    next_fetch_pointer = fetch_pointer;
    next_flags = condition_flags;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    next_operand = operand;
    next_done = 1'b0;
    next_grant = 1'b0;
    next_inhibit = inhibit;
    next_cond = cond_q;
    next_hi = hi_byte;
    unique case (state)
      // Vector fetch: two reads back to back, data one cycle behind
      ST_RV0: begin
        next_mem_rd = 1'b1;
        next_mem_addr = VEC_HI_ADDR;
        next_state = ST_RV1;
      end
      ST_RV1: begin
        next_mem_rd = 1'b1;
        next_mem_addr = VEC_LO_ADDR;
        next_state = ST_RV2;
      end
      ST_RV2: begin
        next_hi = MEM_RDATA;
        next_state = ST_RV3;
      end
      ST_RV3: begin
        next_fetch_pointer = {hi_byte, MEM_RDATA};
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_op = CMD_OP;
          next_cond = CMD_COND;
          next_done = 1'b1;
          unique case (CMD_OP)
            OP_FETCH, OP_IMM8, OP_IMM16, OP_OFFSET: begin
              // Same bus reaches memory, registers and ports
              next_mem_rd = 1'b1;
              next_mem_addr = fetch_pointer;
              next_fetch_pointer = fetch_pointer + PTR_STEP;
              next_done = 1'b0;
              next_state = ST_W1;
            end
            OP_JUMP: begin
              next_fetch_pointer = CMD_TARGET;
            end
            OP_FLAGS: begin
              next_flags = alu_flags;
              next_operand = {BYTE_ZERO, alu_res};
            end
            OP_DECADJ: begin
              next_flags = daa_flags;
              next_operand = {BYTE_ZERO, daa_res};
            end
            OP_MASK_SET: begin
              // Issued by the sequencer once stacking is over
              next_flags[FLG_I] = 1'b1;
            end
            OP_MASK_CLR: begin
              next_flags[FLG_I] = 1'b0;
              next_inhibit = 1'b1;
            end
            OP_BOUNDARY: begin
              next_grant = IRQ_REQ && !condition_flags[FLG_I] &&
                           !inhibit;
              next_inhibit = 1'b0;
            end
            default: begin
              // Register-only and idle codes touch no memory
              next_mem_rd = 1'b0;
            end
          endcase
        end
      end
      ST_W1: begin
        if (op_q == OP_IMM16) begin
          next_mem_rd = 1'b1;
          next_mem_addr = fetch_pointer;
          next_fetch_pointer = fetch_pointer + PTR_STEP;
        end
        next_state = ST_D1;
      end
      ST_D1: begin
        if (op_q == OP_IMM16) begin
          next_hi = MEM_RDATA;
          next_state = ST_D2;
        end else begin
          next_operand = {BYTE_ZERO, MEM_RDATA};
          next_done = 1'b1;
          next_state = ST_IDLE;
          if ((op_q == OP_OFFSET) && cond_q) begin
            next_fetch_pointer = fetch_pointer
                               + {{8{MEM_RDATA[BYTE_MSB]}}, MEM_RDATA};
          end else begin
            // Pointer already stands past the offset byte
            next_fetch_pointer = fetch_pointer;
          end
        end
      end
      ST_D2: begin
        next_operand = {hi_byte, MEM_RDATA};
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_RV0;
      end
    endcase
    // Software write to the flag register, fixed bits forced high
    if (REG_WR && (REG_ADDR == REG_FLAGS)) begin
      next_flags = REG_WDATA;
    end
    next_flags = next_flags | FLAGS_FIXED;
    next_busy = (next_state != ST_IDLE);
    unique case (REG_ADDR)
      REG_FLAGS:  next_rdata = condition_flags | FLAGS_FIXED;
      REG_PTR_LO: next_rdata = fetch_pointer[7:0];
      REG_PTR_HI: next_rdata = fetch_pointer[15:8];
      REG_STATUS: begin
        next_rdata = BYTE_ZERO;
        next_rdata[STAT_BUSY] = busy;
        next_rdata[STAT_INHIBIT] = inhibit;
      end
      default:    next_rdata = BYTE_ZERO;
    endcase
    if (!REG_RD) begin
      next_rdata = BYTE_ZERO;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state           <= ST_RV0;
      op_q            <= OP_NONE;
      fetch_pointer   <= PTR_RESET;
      condition_flags <= FLAGS_RESET;
      mem_addr        <= WORD_ZERO;
      mem_rd          <= 1'b0;
      operand         <= WORD_ZERO;
      done            <= 1'b0;
      busy            <= 1'b1;
      grant           <= 1'b0;
      inhibit         <= 1'b0;
      cond_q          <= 1'b0;
      hi_byte         <= BYTE_ZERO;
      rdata           <= BYTE_ZERO;
    end else if (CLK_EN) begin
      state           <= next_state;
      op_q            <= next_op;
      fetch_pointer   <= next_fetch_pointer;
      condition_flags <= next_flags;
      mem_addr        <= next_mem_addr;
      mem_rd          <= next_mem_rd;
      operand         <= next_operand;
      done            <= next_done;
      busy            <= next_busy;
      grant           <= next_grant;
      inhibit         <= next_inhibit;
      cond_q          <= next_cond;
      hi_byte         <= next_hi;
      rdata           <= next_rdata;
    end
  end

  assign REG_RDATA = rdata;
  assign MEM_ADDR  = mem_addr;
  assign MEM_RD    = mem_rd;
  assign FETCH_PTR = fetch_pointer;
  assign FLAGS     = condition_flags;
  assign OPERAND   = operand;
  assign DONE      = done;
  assign BUSY      = busy;
  assign IRQ_GRANT = grant;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_cmd(pcf_op_t op);
    CLK_EN && take && (CMD_OP == op);
  endsequence

  sequence s_vec_reads;
    MEM_RD && (MEM_ADDR == VEC_HI_ADDR) ##1
    MEM_RD && (MEM_ADDR == VEC_LO_ADDR);
  endsequence

  property p_vec_order;
    (RST_B && CLK_EN && state == ST_RV0) ##1 CLK_EN |-> s_vec_reads;
  endproperty
  a_vec_order: assert property (p_vec_order)
    else $error("reset vector reads out of order");

  property p_vec_load;
    (CLK_EN && state == ST_RV3) |=>
      (fetch_pointer == {$past(hi_byte), $past(MEM_RDATA)}) &&
      state == ST_IDLE;
  endproperty
  a_vec_load: assert property (p_vec_load)
    else $error("reset vector assembled wrongly");

  property p_fixed_ones;
    (condition_flags & FLAGS_FIXED) == FLAGS_FIXED;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones)
    else $error("fixed flag bits not one");

  property p_seq_fetch;
    s_cmd(OP_FETCH) |=> MEM_RD && (MEM_ADDR == $past(fetch_pointer)) &&
                        (fetch_pointer == $past(fetch_pointer) + PTR_STEP);
  endproperty
  a_seq_fetch: assert property (p_seq_fetch)
    else $error("fetch did not step pointer by one");

  property p_jump;
    s_cmd(OP_JUMP) |=> fetch_pointer == $past(CMD_TARGET);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");

  property p_inherent;
    s_cmd(OP_REGONLY) |=> !MEM_RD && DONE && !BUSY;
  endproperty
  a_inherent: assert property (p_inherent)
    else $error("register-only command touched memory");

  property p_rel_taken;
    (CLK_EN && state == ST_D1 && op_q == OP_OFFSET && cond_q) |=>
      fetch_pointer == $past(fetch_pointer) +
                       {{8{$past(MEM_RDATA[BYTE_MSB])}}, $past(MEM_RDATA)};
  endproperty
  a_rel_taken: assert property (p_rel_taken)
    else $error("taken branch target wrong");

  property p_rel_not;
    (CLK_EN && state == ST_D1 && op_q == OP_OFFSET && !cond_q) |=>
      fetch_pointer == $past(fetch_pointer);
  endproperty
  a_rel_not: assert property (p_rel_not)
    else $error("untaken branch moved pointer");

  property p_imm16;
    (CLK_EN && state == ST_D2) |=>
      OPERAND == {$past(hi_byte), $past(MEM_RDATA)} && DONE;
  endproperty
  a_imm16: assert property (p_imm16)
    else $error("wide inline operand byte order wrong");

  property p_mask_block;
    (s_cmd(OP_BOUNDARY) and (condition_flags[FLG_I] == 1'b1)) |=>
      !IRQ_GRANT;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("interrupt granted while masked");

  property p_clr_shadow;
    s_cmd(OP_MASK_CLR) ##1 (CLK_EN && !take) ##1 s_cmd(OP_BOUNDARY) |=>
      !IRQ_GRANT;
  endproperty
  a_clr_shadow: assert property (p_clr_shadow)
    else $error("interrupt taken right after mask clear");

  property p_add_flags;
    (s_cmd(OP_FLAGS) and (ALU_KIND == K_ADD) and !REG_WR) |=>
      FLAGS[FLG_H] == ($past(ALU_A[3:0]) + $past(ALU_B[3:0]) > 5'h0F) &&
      FLAGS[FLG_C] == ($past(ALU_A) + $past(ALU_B) > 9'h0FF);
  endproperty
  a_add_flags: assert property (p_add_flags)
    else $error("add carry flags wrong");

endmodule : pcf_core

// *** test/pcf_mem.sv ***
`timescale 1ns/1ps
module pcf_mem (
  input  wire logic        clk,     // Core clock
  input  wire logic        clk_en,  // Clock enable
  input  wire logic        rd,      // Read strobe
  input  wire logic [15:0] addr,    // Bus address
  output logic [7:0]       rdata    // Read data, cycle after strobe
);
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    if (a == 16'hFFFE) return 8'h12;
    if (a == 16'hFFFF) return 8'h34;
    return a[7:0] ^ a[15:8] ^ 8'hC3;
  endfunction : byte_at

  initial rdata = 8'h5A;
  // Released bus toggles so stale data never matches
  always @(posedge clk) begin
    if (clk_en) rdata <= rd ? byte_at(addr) : ~rdata;
  end
endmodule : pcf_mem

// *** test/cpu_pc_flags_operand_addressing_test.sv ***
`timescale 1ns/1ps
module cpu_pc_flags_operand_addressing_test;
  import pcf_pkg::*;
  logic clk, rst_b, cv, cc, cb, irq, rwr, rrd;
  pcf_op_t op;
  pcf_kind_t kd;
  logic [15:0] tgt, aw, mem_addr, fptr, opnd, p;
  logic [7:0] aa, ab, rdat, wdat, mdat, flg, v;
  logic [3:0] radr;
  logic mem_rd, done, busy, gnt, last_gnt;
  int n_mismatch, n_compared, cyc, rdc;

  pcf_core uut (.REF_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1),
    .CMD_VALID(cv), .CMD_OP(op), .CMD_COND(cc), .CMD_CBIT(cb),
    .CMD_TARGET(tgt), .ALU_KIND(kd), .ALU_A(aa), .ALU_B(ab), .ALU_W(aw),
    .IRQ_REQ(irq), .MEM_RDATA(mdat), .REG_ADDR(radr), .REG_WDATA(wdat),
    .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat), .MEM_ADDR(mem_addr),
    .MEM_RD(mem_rd), .FETCH_PTR(fptr), .FLAGS(flg), .OPERAND(opnd),
    .DONE(done), .BUSY(busy), .IRQ_GRANT(gnt));
  pcf_mem mem (.clk(clk), .clk_en(1'b1), .rd(mem_rd), .addr(mem_addr),
    .rdata(mdat));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mem_rd === 1'b1) rdc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_cmd(input pcf_op_t o, input int lat, input int nrd,
      input logic c = 0, input logic [15:0] t = 0,
      input pcf_kind_t k = K_ADD, input logic [7:0] a = 0, b = 0,
      input logic [15:0] w = 0, input logic x = 0);
    int n, r0;
    @(posedge clk);
    cv <= 1'b1; op <= o; cc <= c; tgt <= t; kd <= k;
    aa <= a; ab <= b; aw <= w; cb <= x;
    @(posedge clk);
    cv <= 1'b0;
    r0 = rdc;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    last_gnt = gnt;
    chk("latency", lat, n);
    chk("reads", nrd, rdc - r0);
  endtask : do_cmd

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    rwr <= 1'b1; radr <= a; wdat <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rrd <= 1'b1; radr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1 d = rdat;
  endtask : reg_rd

  task automatic t_vector;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("vector time", 16'h0003, n[15:0]);
    chk("vector busy", 16'h0000, {15'h0, busy});
    chk("vector", 16'h1234, fptr);
    chk("flags", 16'h0068, {8'h00, flg});
  endtask : t_vector

  task automatic t_flow;
    p = fptr;
    do_cmd(OP_FETCH, 3, 1);
    chk("fetch", {8'h00, mem.byte_at(p)}, opnd);
    chk("fetch ptr", p + 16'h0001, fptr);
    p = fptr;
    do_cmd(OP_IMM16, 4, 2);
    chk("imm16", {mem.byte_at(p), mem.byte_at(p + 1)}, opnd);
    chk("imm16 ptr", p + 16'h0002, fptr);
    p = fptr;
    v = mem.byte_at(p);
    do_cmd(OP_OFFSET, 3, 1, 1'b1);
    chk("rel taken", p + 16'h0001 + {{8{v[7]}}, v}, fptr);
    p = fptr;
    do_cmd(OP_OFFSET, 3, 1, 1'b0);
    chk("rel untaken", p + 16'h0001, fptr);
    p = fptr;
    do_cmd(OP_REGONLY, 1, 0);
    chk("inh ptr", p, fptr);
    do_cmd(OP_JUMP, 1, 0, 1'b0, 16'h8000);
    chk("jump", 16'h8000, fptr);
  endtask : t_flow

  task automatic t_flags;
    pcf_kind_t k[9] = '{K_ADD, K_ADD, K_SUB, K_SHIFT, K_ADC, K_SBC,
      K_LOGIC, K_LOAD16, K_LOAD16};
    logic [7:0] a[9] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'h08, 8'h80,
      8'hFF, 8'h00, 8'h00};
    logic [7:0] b[9] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h08, 8'h01,
      8'hFF, 8'h00, 8'h00};
    logic [15:0] w[9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0000, 16'h8000};
    logic [7:0] e[9] = '{8'hF4, 8'h73, 8'h65, 8'h61, 8'h70, 8'hE0,
      8'h60, 8'h62, 8'h64};
    logic [7:0] m[9] = '{8'hF7, 8'hF7, 8'hE7, 8'h61, 8'hF7, 8'hE7,
      8'hE0, 8'hE6, 8'hE6};
    for (int i = 0; i < 9; i++) begin
      do_cmd(OP_FLAGS, 1, 0, 1'b0, 16'h0, k[i], a[i], b[i], w[i], 1'b1);
      chk("flag set", {8'h00, e[i]}, {8'h00, flg & m[i]});
    end
    do_cmd(OP_FLAGS, 1, 0, 1'b0, 16'h0, K_ADD, 8'h15, 8'h27);
    do_cmd(OP_DECADJ, 1, 0, 1'b0, 16'h0, K_ADD, 8'h3C);
    chk("decimal", 16'h0042, {8'h00, opnd[7:0]});
    do_cmd(OP_FLAGS, 1, 0, 1'b0, 16'h0, K_ADD, 8'h09, 8'h09);
    do_cmd(OP_DECADJ, 1, 0, 1'b0, 16'h0, K_ADD, 8'h12);
    chk("decimal nib", 16'h0018, opnd);
    do_cmd(OP_FLAGS, 1, 0, 1'b0, 16'h0, K_ADD, 8'h90, 8'h90);
    do_cmd(OP_DECADJ, 1, 0, 1'b0, 16'h0, K_ADD, 8'h20);
    chk("decimal hi", 16'h0180, {7'h00, flg[FLG_C], opnd[7:0]});
  endtask : t_flags

  task automatic t_mask;
    irq <= 1'b1;
    do_cmd(OP_MASK_CLR, 1, 0);
    chk("mask clr", 16'h0000, {15'h0, flg[FLG_I]});
    reg_rd(REG_STATUS, v);
    chk("status shadow", 16'h0002, {8'h00, v});
    do_cmd(OP_BOUNDARY, 1, 0);
    chk("grant shadow", 16'h0000, {15'h0, last_gnt});
    do_cmd(OP_BOUNDARY, 1, 0);
    chk("grant open", 16'h0001, {15'h0, last_gnt});
    do_cmd(OP_MASK_SET, 1, 0);
    do_cmd(OP_BOUNDARY, 1, 0);
    chk("grant masked", 16'h0000, {15'h0, last_gnt});
  endtask : t_mask

  task automatic t_regs;
    reg_wr(REG_FLAGS, 8'h00);
    reg_rd(REG_FLAGS, v);
    chk("reg flags", 16'h0060, {8'h00, v});
    reg_wr(REG_PTR_LO, 8'h55);
    reg_rd(REG_PTR_LO, v);
    chk("reg ptr lo", 16'h0000, {8'h00, v});
    reg_rd(REG_PTR_HI, v);
    chk("reg ptr hi", 16'h0080, {8'h00, v});
    reg_rd(4'hF, v);
    chk("reg unmapped", 16'h0000, {8'h00, v});
  endtask : t_regs

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    {cv, cc, cb, irq, rwr, rrd} = 6'h00;
    op = OP_NONE; kd = K_ADD; tgt = 16'h0000; aw = 16'h0000;
    aa = 8'h00; ab = 8'h00; wdat = 8'h00; radr = 4'h0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_vector();
    t_flow();
    t_flags();
    t_mask();
    t_regs();
    summarize();
  end
endmodule : cpu_pc_flags_operand_addressing_test
